// ==== src/gioc_consts.vh ====
// Constants for the global interrupt and output control block
`ifndef GIOC_CONSTS_VH
`define GIOC_CONSTS_VH
`define GIOC_ADDR_W 12
`define GIOC_ADDR_FRMR_STAT 12'h000
`define GIOC_ADDR_FRMR_EN 12'h001
`define GIOC_ADDR_LINK_STAT 12'h002
`define GIOC_ADDR_LINK_EN 12'h003
`define GIOC_ADDR_GCTRL 12'h004
`define GIOC_ADDR_DEV_LO 12'h005
`define GIOC_ADDR_DEV_HI 12'h006
`define GIOC_ADDR_VERSION 12'h007
`define GIOC_EN_RST 8'h00
`define GIOC_GCTRL_RST 8'h00
`define GIOC_GCTRL_WMASK 8'h57
`define GIOC_SEL_B0 2
`define GIOC_SEL_B1 1
`define GIOC_SEL_B2 0
`define GIOC_TRISTATE_BIT 4
`define GIOC_POLARITY_BIT 6
`define GIOC_DEV_LO_DEF 8'h5a
`define GIOC_DEV_HI_DEF 8'h3c
`define GIOC_VERSION_DEF 8'h01
`endif

// ==== src/gioc_pin_drive.v ====
// Interrupt pin driver with polarity and three-state options
`timescale 1ns/1ps
module gioc_pin_drive (
  // Control
  input wire active_i,
  input wire tristate_i,
  input wire polarity_i,
  // Pin
  output wire pin_o,
  output wire pin_oe_o
);
  // Active level is high unless polarity inverts it
  assign pin_o = active_i ^ polarity_i;
  // In three-state mode the pin is released while idle
  assign pin_oe_o = tristate_i ? active_i : 1'b1;
endmodule // gioc_pin_drive

// ==== src/gioc_global_ctrl.v ====
// Global interrupt gating, output control and identification registers
`timescale 1ns/1ps
`include "gioc_consts.vh"
module gioc_global_ctrl #(
  parameter [7:0] DEV_LO = `GIOC_DEV_LO_DEF, // Arbitrary identification value
  parameter [7:0] DEV_HI = `GIOC_DEV_HI_DEF, // Arbitrary identification value
  parameter [7:0] VERSION = `GIOC_VERSION_DEF // Arbitrary identification value
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Register port
  input wire [`GIOC_ADDR_W-1:0] addr_i,
  input wire wr_i,
  input wire rd_i,
  input wire [7:0] wdata_i,
  output reg [7:0] rdata_o,
  // Interrupt event pulses from the framer and link blocks
  input wire [7:0] framer_irq_i,
  input wire [7:0] link_irq_i,
  // One-second pulses from the eight framers
  input wire [7:0] framer_sec_i,
  output reg second_o,
  // Interrupt pin
  output wire irq_o,
  output wire irq_oe_o
);
  // Register state and next values
  reg [7:0] frmr_stat_q;
  reg [7:0] frmr_stat_d;
  reg [7:0] frmr_en_q;
  reg [7:0] frmr_en_d;
  reg [7:0] link_stat_q;
  reg [7:0] link_stat_d;
  reg [7:0] link_en_q;
  reg [7:0] link_en_d;
  reg [7:0] gctrl_q;
  reg [7:0] gctrl_d;
  reg irq_act_q;
  reg irq_act_d;
  reg second_d;
  reg [7:0] rdata_d;
  // Decoded strobes and gated conditions
  wire wr_frmr_en;
  wire wr_link_en;
  wire wr_gctrl;
  wire rd_frmr;
  wire rd_link;
  wire frmr_pend;
  wire link_pend;
  wire [2:0] sel;
  wire pin_tristate;
  wire pin_polarity;

  // Write strobe for one register address; the strobe is an argument so callers see its changes
  function wen;
    input wr;
    input [`GIOC_ADDR_W-1:0] a;
    input [`GIOC_ADDR_W-1:0] target;
    begin
      wen = wr && (a == target);
    end
  endfunction

  // Clear on read; an event in the clearing cycle is kept, not lost
  function [7:0] stat_next;
    input [7:0] cur;
    input clr;
    input [7:0] ev;
    begin
      stat_next = (clr ? 8'h00 : cur) | ev;
    end
  endfunction

  // Any block that is both pending and enabled
  function pending;
    input [7:0] stat;
    input [7:0] en;
    begin
      pending = |(stat & en);
    end
  endfunction

  // Bit 0 of the field is the most significant select bit
  function [2:0] sec_sel;
    input [7:0] ctrl;
    begin
      sec_sel = {ctrl[`GIOC_SEL_B2], ctrl[`GIOC_SEL_B1], ctrl[`GIOC_SEL_B0]};
    end
  endfunction

  assign wr_frmr_en = wen(wr_i, addr_i, `GIOC_ADDR_FRMR_EN);
  assign wr_link_en = wen(wr_i, addr_i, `GIOC_ADDR_LINK_EN);
  assign wr_gctrl = wen(wr_i, addr_i, `GIOC_ADDR_GCTRL);
  assign rd_frmr = rd_i && (addr_i == `GIOC_ADDR_FRMR_STAT);
  assign rd_link = rd_i && (addr_i == `GIOC_ADDR_LINK_STAT);
  assign frmr_pend = pending(frmr_stat_q, frmr_en_q);
  assign link_pend = pending(link_stat_q, link_en_q);
  assign sel = sec_sel(gctrl_q);
  assign pin_tristate = gctrl_q[`GIOC_TRISTATE_BIT];
  assign pin_polarity = gctrl_q[`GIOC_POLARITY_BIT];

  // Next status byte for each block family
  always @* begin
    frmr_stat_d = stat_next(frmr_stat_q, rd_frmr, framer_irq_i);
    link_stat_d = stat_next(link_stat_q, rd_link, link_irq_i);
  end

  // Host writes; anything not decoded here is read-only
  always @* begin
    frmr_en_d = frmr_en_q;
    link_en_d = link_en_q;
    gctrl_d = gctrl_q;
    if (wr_frmr_en) begin
      frmr_en_d = wdata_i;
    end
    if (wr_link_en) begin
      link_en_d = wdata_i;
    end
    if (wr_gctrl) begin
      // Reserved bits never store, so they always read back zero
      gctrl_d = wdata_i & `GIOC_GCTRL_WMASK;
    end
  end

  // Pending and enabled from either block family drives the pin
  always @* begin
    irq_act_d = frmr_pend | link_pend;
  end

  always @* begin
    second_d = framer_sec_i[sel];
  end

  // Identification bytes have no write decode, so writes fall away
  always @* begin
    rdata_d = rdata_o;
    if (rd_i) begin
      case (addr_i)
        `GIOC_ADDR_FRMR_STAT: rdata_d = frmr_stat_q;
        `GIOC_ADDR_FRMR_EN: rdata_d = frmr_en_q;
        `GIOC_ADDR_LINK_STAT: rdata_d = link_stat_q;
        `GIOC_ADDR_LINK_EN: rdata_d = link_en_q;
        `GIOC_ADDR_GCTRL: rdata_d = gctrl_q;
        `GIOC_ADDR_DEV_LO: rdata_d = DEV_LO;
        `GIOC_ADDR_DEV_HI: rdata_d = DEV_HI;
        `GIOC_ADDR_VERSION: rdata_d = VERSION;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // Status bytes flag events only; several events before a read show as one
  always @(posedge clk_i) begin
    if (rst_i) begin
      frmr_stat_q <= 8'h00;
      link_stat_q <= 8'h00;
    end else begin
      frmr_stat_q <= frmr_stat_d;
      link_stat_q <= link_stat_d;
    end
  end

  // Enable and control bytes
  always @(posedge clk_i) begin
    if (rst_i) begin
      frmr_en_q <= `GIOC_EN_RST;
      link_en_q <= `GIOC_EN_RST;
      gctrl_q <= `GIOC_GCTRL_RST;
    end else begin
      frmr_en_q <= frmr_en_d;
      link_en_q <= link_en_d;
      gctrl_q <= gctrl_d;
    end
  end

  // Registered so status decode glitches never reach the pin
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_act_q <= 1'b0;
    end else begin
      irq_act_q <= irq_act_d;
    end
  end

  // One cycle of latency on the selected pulse, none dropped
  always @(posedge clk_i) begin
    if (rst_i) begin
      second_o <= 1'b0;
    end else begin
      second_o <= second_d;
    end
  end

  // Read data stands until the next read strobe
  always @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= rdata_d;
    end
  end

  // Pin driver: polarity and release options
  gioc_pin_drive u_pin (
    .active_i(irq_act_q),
    .tristate_i(pin_tristate),
    .polarity_i(pin_polarity),
    .pin_o(irq_o),
    .pin_oe_o(irq_oe_o)
  );
endmodule // gioc_global_ctrl

// ==== test/gioc_host.sv ====
// Host side of the shared interrupt line
`timescale 1ns/1ps
module gioc_host (input wire pin_i, input wire oe_i, output wire line_o);
  // A released line rests at the pull-up
  assign line_o = oe_i ? pin_i : 1'b1;
endmodule // gioc_host

// ==== test/gioc_checker.sv ====
// Port checker for the interrupt and output control block
`timescale 1ns/1ps
module gioc_checker (
  input wire clk_i, rst_i, wr_i, rd_i, second_o, irq_o, irq_oe_o,
  input wire [11:0] addr_i,
  input wire [7:0] wdata_i, rdata_o, framer_irq_i, link_irq_i, framer_sec_i
);
  logic [7:0] g_q, le_q, fe_q;
  logic sec_q;
  always @(posedge clk_i) g_q <= rst_i ? 8'h00 : wr_i && addr_i == 12'h004 ? wdata_i : g_q;
  always @(posedge clk_i) le_q <= rst_i ? 8'h00 : wr_i && addr_i == 12'h003 ? wdata_i : le_q;
  always @(posedge clk_i) fe_q <= rst_i ? 8'h00 : wr_i && addr_i == 12'h001 ? wdata_i : fe_q;
  always @(posedge clk_i) sec_q <= !rst_i && framer_sec_i[{g_q[0], g_q[1], g_q[2]}];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_ev; |(link_irq_i & le_q); endsequence
  sequence s_fev; |(framer_irq_i & fe_q); endsequence
  sequence s_act; irq_oe_o && irq_o != g_q[6]; endsequence
  AST_RAISE: assert property (s_ev |-> ##[1:3] s_act) else $error("no raise");
  AST_FRAISE: assert property (s_fev |-> ##[1:3] s_act) else $error("no framer raise");
  AST_DRIVE: assert property (!g_q[4] |-> irq_oe_o) else $error("released");
  AST_TRI: assert property (g_q[4] && irq_oe_o |-> irq_o != g_q[6]) else $error("level");
  AST_SEC: assert property (second_o == sec_q) else $error("pulse");
  AST_DEVLO: assert property (rd_i && addr_i == 12'h005 |=> rdata_o == 8'h5a) else $error("id");
  AST_DEVHI: assert property (rd_i && addr_i == 12'h006 |=> rdata_o == 8'h3c) else $error("id");
  AST_VER: assert property (rd_i && addr_i == 12'h007 |=> rdata_o == 8'h01) else $error("ver");
  AST_RSV: assert property (rd_i && addr_i == 12'h004 |=> !(rdata_o & 8'ha8)) else $error("rsv");
endmodule // gioc_checker
bind gioc_global_ctrl gioc_checker chk (.*);

// ==== test/gioc_global_ctrl_tb.sv ====
// Testbench for the interrupt and output control block
`timescale 1ns/1ps
module gioc_global_ctrl_tb;
  logic clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, second_o, irq_o, irq_oe_o, line;
  logic [11:0] addr_i = 0;
  logic [7:0] wdata_i = 0, rdata_o, framer_irq_i = 0, link_irq_i = 0, framer_sec_i = 0;
  int fail_count = 0, compares = 0;
  gioc_global_ctrl dut (.*);
  gioc_host host (.pin_i(irq_o), .oe_i(irq_oe_o), .line_o(line));
  initial forever #12.5 clk_i = ~clk_i;
  task chk(string n, logic [7:0] s, e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task bus(logic w, logic [11:0] a, logic [7:0] d);
    @(posedge clk_i);
    #2 {wr_i, rd_i, addr_i, wdata_i} = {w, !w, a, d};
    @(posedge clk_i);
    #2 {wr_i, rd_i} = 2'b00;
  endtask
  task pulse(logic [7:0] f, l, logic [1:0] e);
    @(posedge clk_i);
    #2 {framer_irq_i, link_irq_i} = {f, l};
    @(posedge clk_i);
    #2 {framer_irq_i, link_irq_i} = 16'h0000;
    repeat (2) @(posedge clk_i);
    #2 chk("pin", {6'h00, irq_oe_o, line}, {6'h00, e});
  endtask
  task t_regs;
    bus(1, 12'h005, 8'hff);
    bus(0, 12'h005, 0);
    chk("id", rdata_o, 8'h5a);
    bus(0, 12'h006, 0);
    chk("id high", rdata_o, 8'h3c);
    bus(0, 12'h007, 0);
    chk("version", rdata_o, 8'h01);
    bus(1, 12'h004, 8'hff);
    bus(0, 12'h004, 0);
    chk("ctrl", rdata_o, 8'h57);
  endtask
  task t_sec;
    for (int k = 0; k < 8; k++) begin
      bus(1, 12'h004, {5'h00, k[0], k[1], k[2]});
      #25 framer_sec_i = 8'h01 << k;
      #25 chk("second", {7'h00, second_o}, 8'h01);
    end
  endtask
  task t_irq;
    logic [1:0] idle;
    bus(1, 12'h003, 8'h08);
    for (int m = 0; m < 4; m++) begin
      idle = {!m[0], m[0] | m[1]};
      bus(1, 12'h004, {1'b0, m[1], 1'b0, m[0], 4'h0});
      pulse(8'h80, 8'h04, idle);
      pulse(0, 8'h08, {1'b1, !m[1]});
      bus(0, 12'h002, 0);
      chk("stat", rdata_o, 8'h0c);
      pulse(0, 0, idle);
    end
  endtask
  task t_frmr;
    bus(1, 12'h004, 8'h00);
    bus(0, 12'h000, 0);
    chk("framer stat", rdata_o, 8'h80);
    bus(1, 12'h001, 8'h80);
    pulse(8'h40, 0, 2'b10);
    pulse(8'h80, 0, 2'b11);
    bus(0, 12'h000, 0);
    chk("framer stat", rdata_o, 8'hc0);
    pulse(0, 0, 2'b10);
  endtask
  task t_rst;
    bus(1, 12'h003, 8'hff);
    bus(1, 12'h004, 8'h50);
    @(posedge clk_i);
    #2 rst_i = 1;
    @(posedge clk_i);
    #2 rst_i = 0;
    chk("reset pin", {6'h00, irq_oe_o, irq_o}, 8'h02);
    chk("reset second", {7'h00, second_o}, 8'h00);
    bus(0, 12'h003, 0);
    chk("reset enable", rdata_o, 8'h00);
    bus(0, 12'h004, 0);
    chk("reset control", rdata_o, 8'h00);
  endtask
  task test_done;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    #2 rst_i = 0;
    t_regs;
    t_sec;
    t_irq;
    t_frmr;
    t_rst;
    test_done;
  end
  initial begin
    #20000 fail_count++;
    test_done;
  end
endmodule // gioc_global_ctrl_tb
